// [bcc_ctrl.sv]
// Bit-oriented code controller for the facility data link
module bcc_ctrl (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register port
   input wire bcc_pkg::bcc_bus_s reg_bus,
   output logic [7:0] reg_rdata,
   // Line mode and status inputs
   input wire logic t1_mode,
   input wire logic alarm_ci_detect,
   input wire logic tx_clock_pin,
   input wire logic mclk_scaled_tick,
   // Link transmit slot
   input wire logic fdl_tx_req,
   output logic fdl_tx_bit,
   // Link receive bits
   input wire logic fdl_rx_valid,
   input wire logic fdl_rx_bit,
   output logic fdl_rx_ready,
   // Interrupt
   output logic irq
);

   // ------------------------------------------------------------
   // Host registers
   // ------------------------------------------------------------
   logic [7:0] ctrl_r, ctrl_nxt, mask_r, mask_nxt;
   logic [7:0] match_a_r, match_a_nxt, match_b_r, match_b_nxt;
   logic [7:0] txbuf_r, txbuf_nxt, rdata_r, rdata_nxt;
   logic txbuf_full_r, txbuf_full_nxt;
   logic [7:0] status_r, status_nxt, ev_set;
   logic wr_txbuf, rd_status, rd_rxlink, txbuf_take;
   logic [5:0] code_r, code_nxt;
   logic [7:0] rl_val;
   logic [7:0] fifo_data;
   logic fifo_valid, fifo_full, fifo_pop, fifo_in_ready;

   // Address decode
   assign wr_txbuf = reg_bus.wr && reg_bus.addr == bcc_pkg::OFF_TX_LINK;
   assign rd_status = reg_bus.rd && reg_bus.addr == bcc_pkg::OFF_STATUS;
   assign rd_rxlink = reg_bus.rd && reg_bus.addr == bcc_pkg::OFF_RX_LINK;

   // Receive link register view: code or buffered byte
   always_comb begin
      if (ctrl_r[bcc_pkg::CTRL_RXEN]) begin
         rl_val = {2'b00, code_r};
      end else begin
         rl_val = fifo_valid ? fifo_data : bcc_pkg::RST_REG;
      end
   end
   assign fifo_pop = rd_rxlink && !ctrl_r[bcc_pkg::CTRL_RXEN];

   // Register writes, read data and sticky events
   always_comb begin
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      match_a_nxt = match_a_r;
      match_b_nxt = match_b_r;
      txbuf_nxt = txbuf_r;
      rdata_nxt = rdata_r;
      if (reg_bus.wr) begin
         case (reg_bus.addr)
            bcc_pkg::OFF_CTRL: ctrl_nxt = reg_bus.wdata & bcc_pkg::CTRL_WMASK;
            bcc_pkg::OFF_MASK: mask_nxt = reg_bus.wdata;
            bcc_pkg::OFF_MATCH_A: match_a_nxt = reg_bus.wdata;
            bcc_pkg::OFF_MATCH_B: match_b_nxt = reg_bus.wdata;
            bcc_pkg::OFF_TX_LINK: txbuf_nxt = reg_bus.wdata;
            default: ;
         endcase
      end
      if (reg_bus.rd) begin
         case (reg_bus.addr)
            bcc_pkg::OFF_STATUS: rdata_nxt = status_r;
            bcc_pkg::OFF_MASK: rdata_nxt = mask_r;
            bcc_pkg::OFF_CTRL: rdata_nxt = ctrl_r;
            bcc_pkg::OFF_RX_LINK: rdata_nxt = rl_val;
            bcc_pkg::OFF_MATCH_A: rdata_nxt = match_a_r;
            bcc_pkg::OFF_MATCH_B: rdata_nxt = match_b_r;
            default: rdata_nxt = bcc_pkg::RST_REG;
         endcase
      end
      // A new write refills even while the shifter takes the old byte
      txbuf_full_nxt = wr_txbuf ? 1'b1 : (txbuf_take ? 1'b0 : txbuf_full_r);
      // Clear on read, a same-cycle event still lands
      status_nxt = (rd_status ? bcc_pkg::RST_REG : status_r) | ev_set;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl_r <= bcc_pkg::RST_REG;
         mask_r <= bcc_pkg::RST_REG;
         match_a_r <= bcc_pkg::RST_REG;
         match_b_r <= bcc_pkg::RST_REG;
         txbuf_r <= bcc_pkg::RST_REG;
         txbuf_full_r <= 1'b0;
         rdata_r <= bcc_pkg::RST_REG;
         status_r <= bcc_pkg::RST_REG;
      end else begin
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
         match_a_r <= match_a_nxt;
         match_b_r <= match_b_nxt;
         txbuf_r <= txbuf_nxt;
         txbuf_full_r <= txbuf_full_nxt;
         rdata_r <= rdata_nxt;
         status_r <= status_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq = |(status_r & mask_r);

   // ------------------------------------------------------------
   // Transmit side
   // ------------------------------------------------------------
   bcc_pkg::bcc_tx_e tx_st_r, tx_st_nxt;
   logic [15:0] tx_sh_r, tx_sh_nxt;
   logic [3:0] tx_cnt_r, tx_cnt_nxt;
   logic tx_bit_r, tx_bit_nxt, code_on;
   logic [15:0] frame;

   assign code_on = t1_mode && ctrl_r[bcc_pkg::CTRL_SEND];
   assign frame = bcc_pkg::code_frame(txbuf_r[5:0]);

   // Slot by slot bit selection
   always_comb begin
      tx_st_nxt = tx_st_r;
      tx_sh_nxt = tx_sh_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_bit_nxt = tx_bit_r;
      txbuf_take = 1'b0;
      if (fdl_tx_req) begin
         if (code_on && (tx_st_r != bcc_pkg::TX_CODE || tx_cnt_r == 4'd0)) begin
            // Fresh frame, also abandons a byte in flight
            tx_st_nxt = bcc_pkg::TX_CODE;
            tx_bit_nxt = frame[0];
            tx_sh_nxt = {1'b0, frame[15:1]};
            tx_cnt_nxt = 4'd1;
         end else if (code_on) begin
            tx_bit_nxt = tx_sh_r[0];
            tx_sh_nxt = {1'b0, tx_sh_r[15:1]};
            tx_cnt_nxt = tx_cnt_r + 4'd1;
         end else if (tx_st_r == bcc_pkg::TX_DATA && tx_cnt_r != bcc_pkg::BYTE_BITS) begin
            tx_bit_nxt = tx_sh_r[0];
            tx_sh_nxt = {1'b0, tx_sh_r[15:1]};
            tx_cnt_nxt = tx_cnt_r + 4'd1;
         end else if (txbuf_full_r) begin
            tx_st_nxt = bcc_pkg::TX_DATA;
            tx_bit_nxt = txbuf_r[0];
            tx_sh_nxt = {9'h000, txbuf_r[7:1]};
            tx_cnt_nxt = 4'd1;
            txbuf_take = 1'b1;
         end else begin
            // Idle fill of ones
            tx_st_nxt = bcc_pkg::TX_IDLE;
            tx_bit_nxt = 1'b1;
            tx_cnt_nxt = 4'd0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tx_st_r <= bcc_pkg::TX_IDLE;
         tx_sh_r <= 16'h0000;
         tx_cnt_r <= 4'h0;
         tx_bit_r <= 1'b1;
      end else begin
         tx_st_r <= tx_st_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_bit_r <= tx_bit_nxt;
      end
   end

   assign fdl_tx_bit = tx_bit_r;

   // ------------------------------------------------------------
   // Receive side: code detector, abort and clear watch, byte path
   // ------------------------------------------------------------
   logic [15:0] win_r, win_nxt;
   logic [5:0] cand_r, cand_nxt;
   logic [2:0] rep_r, rep_nxt;
   logic [4:0] since_r, since_nxt, clr_cnt_r, clr_cnt_nxt;
   logic [3:0] ones_r, ones_nxt, asm_cnt_r, asm_cnt_nxt;
   logic [7:0] asm_r, asm_nxt, rl_prev_r;
   logic rst_prev_r, rxen_prev_r, full_prev_r;
   logic det_reset, rx_take, asm_hold, ev_code, ev_abort, ev_clear;
   logic frame_ok;

   assign det_reset = (ctrl_r[bcc_pkg::CTRL_RST] && !rst_prev_r)
      || (ctrl_r[bcc_pkg::CTRL_RXEN] && !rxen_prev_r);
   assign rx_take = fdl_rx_valid && fdl_rx_ready && t1_mode;
   assign asm_hold = (asm_cnt_r == bcc_pkg::BYTE_BITS);
   assign fdl_rx_ready = !asm_hold;

   // Detector and byte assembly next state
   always_comb begin
      win_nxt = win_r;
      code_nxt = code_r;
      cand_nxt = cand_r;
      rep_nxt = rep_r;
      since_nxt = since_r;
      clr_cnt_nxt = clr_cnt_r;
      ones_nxt = ones_r;
      asm_nxt = asm_r;
      asm_cnt_nxt = asm_cnt_r;
      ev_code = 1'b0;
      ev_abort = 1'b0;
      ev_clear = 1'b0;
      frame_ok = 1'b0;
      if (det_reset) begin
         win_nxt = 16'h0000;
         code_nxt = bcc_pkg::CODE_PRESET;
         cand_nxt = bcc_pkg::CODE_PRESET;
         rep_nxt = 3'd0;
         since_nxt = 5'd0;
         clr_cnt_nxt = 5'd0;
         ones_nxt = 4'd0;
      end else if (rx_take) begin
         // Abort: eight ones in a row
         ones_nxt = fdl_rx_bit ? ones_r + 4'd1 : 4'd0;
         if (ones_r == bcc_pkg::ABORT_ONES) begin
            ones_nxt = fdl_rx_bit ? bcc_pkg::ABORT_ONES : 4'd0;
         end
         ev_abort = fdl_rx_bit && ones_r == bcc_pkg::ABORT_ONES - 4'd1;
         // Clear: thirty bits with no abort
         if (ev_abort) begin
            clr_cnt_nxt = 5'd0;
         end else if (clr_cnt_r != bcc_pkg::CLEAR_BITS) begin
            clr_cnt_nxt = clr_cnt_r + 5'd1;
            ev_clear = (clr_cnt_r == bcc_pkg::CLEAR_BITS - 5'd1);
         end
         if (ctrl_r[bcc_pkg::CTRL_RXEN]) begin
            win_nxt = {fdl_rx_bit, win_r[15:1]};
            frame_ok = win_nxt[7:0] == 8'hFF && !win_nxt[8] && !win_nxt[15];
            since_nxt = (since_r == bcc_pkg::FRAME_BITS) ? since_r : since_r + 5'd1;
            if (frame_ok) begin
               since_nxt = 5'd0;
               // A gap breaks the run of identical codes
               if (win_nxt[14:9] == cand_r && since_r == bcc_pkg::FRAME_BITS - 5'd1) begin
                  rep_nxt = (rep_r == bcc_pkg::REP_MAX) ? rep_r : rep_r + 3'd1;
               end else begin
                  cand_nxt = win_nxt[14:9];
                  rep_nxt = 3'd1;
               end
               if (rep_nxt == bcc_pkg::filt_need(ctrl_r[2:1]) && cand_nxt != code_r) begin
                  code_nxt = cand_nxt;
                  ev_code = 1'b1;
               end
            end
         end else begin
            // Plain bytes, first bit lands in bit 0
            asm_nxt = {fdl_rx_bit, asm_r[7:1]};
            asm_cnt_nxt = asm_cnt_r + 4'd1;
         end
      end
      // Completed byte waits here until the buffer takes it
      if (asm_hold && fifo_in_ready) begin
         asm_cnt_nxt = 4'd0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         win_r <= 16'h0000;
         code_r <= 6'h00;
         cand_r <= 6'h00;
         rep_r <= 3'h0;
         since_r <= 5'h00;
         clr_cnt_r <= 5'h00;
         ones_r <= 4'h0;
         asm_r <= 8'h00;
         asm_cnt_r <= 4'h0;
         rst_prev_r <= 1'b0;
         rxen_prev_r <= 1'b0;
         full_prev_r <= 1'b0;
         rl_prev_r <= 8'h00;
      end else begin
         win_r <= win_nxt;
         code_r <= code_nxt;
         cand_r <= cand_nxt;
         rep_r <= rep_nxt;
         since_r <= since_nxt;
         clr_cnt_r <= clr_cnt_nxt;
         ones_r <= ones_nxt;
         asm_r <= asm_nxt;
         asm_cnt_r <= asm_cnt_nxt;
         rst_prev_r <= ctrl_r[bcc_pkg::CTRL_RST];
         rxen_prev_r <= ctrl_r[bcc_pkg::CTRL_RXEN];
         full_prev_r <= fifo_full;
         rl_prev_r <= rl_val;
      end
   end

   // Receive byte buffer between link and host
   bcc_fifo #(
      .W(bcc_pkg::FIFO_WIDTH),
      .D(bcc_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(asm_hold),
      .in_ready(fifo_in_ready),
      .in_data(asm_r),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data),
      .full(fifo_full)
   );

   // ------------------------------------------------------------
   // Transmit clock watch
   // ------------------------------------------------------------
   logic tx_clock_pin_prev_r;
   logic [3:0] loss_cnt_r, loss_cnt_nxt;
   logic ev_loss;

   // Count scaled ticks with no edge on the transmit clock pin
   always_comb begin
      loss_cnt_nxt = loss_cnt_r;
      ev_loss = 1'b0;
      if (tx_clock_pin != tx_clock_pin_prev_r) begin
         loss_cnt_nxt = 4'd0;
      end else if (mclk_scaled_tick && loss_cnt_r != bcc_pkg::CLK_LOSS_TICKS) begin
         loss_cnt_nxt = loss_cnt_r + 4'd1;
         ev_loss = (loss_cnt_r == bcc_pkg::CLK_LOSS_TICKS - 4'd1);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tx_clock_pin_prev_r <= 1'b0;
         loss_cnt_r <= 4'h0;
      end else begin
         tx_clock_pin_prev_r <= tx_clock_pin;
         loss_cnt_r <= loss_cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // Event collection
   // ------------------------------------------------------------
   always_comb begin
      ev_set = bcc_pkg::RST_REG;
      ev_set[bcc_pkg::EV_CODE] = ev_code;
      ev_set[bcc_pkg::EV_MATCH] = (rl_val != rl_prev_r)
         && (rl_val == match_a_r || rl_val == match_b_r);
      ev_set[bcc_pkg::EV_TXEMPTY] = txbuf_take && !wr_txbuf;
      ev_set[bcc_pkg::EV_RXFULL] = fifo_full && !full_prev_r;
      ev_set[bcc_pkg::EV_ABORT] = ev_abort;
      ev_set[bcc_pkg::EV_CLEAR] = ev_clear;
      ev_set[bcc_pkg::EV_CLKLOSS] = ev_loss;
      ev_set[bcc_pkg::EV_ALARM] = alarm_ci_detect && t1_mode;
   end

endmodule

// [bcc_pkg.sv]
// Constants, types and helpers shared by the bit-oriented code controller
package bcc_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_MASK = 8'h19;
   localparam logic [7:0] OFF_CTRL = 8'h1F;
   localparam logic [7:0] OFF_RX_LINK = 8'h50;
   localparam logic [7:0] OFF_TX_LINK = 8'h51;
   localparam logic [7:0] OFF_MATCH_A = 8'h52;
   localparam logic [7:0] OFF_MATCH_B = 8'h53;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [5:0] CODE_PRESET = 6'h3F;

   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTRL_SEND = 0;
   localparam int CTRL_FLT_LO = 1;
   localparam int CTRL_FLT_HI = 2;
   localparam int CTRL_RST = 3;
   localparam int CTRL_RXEN = 4;
   localparam logic [7:0] CTRL_WMASK = 8'h1F;

   // ------------------------------------------------------------
   // Event status bit positions
   // ------------------------------------------------------------
   localparam int EV_CODE = 0;
   localparam int EV_MATCH = 1;
   localparam int EV_TXEMPTY = 2;
   localparam int EV_RXFULL = 3;
   localparam int EV_ABORT = 4;
   localparam int EV_CLEAR = 5;
   localparam int EV_CLKLOSS = 6;
   localparam int EV_ALARM = 7;

   // ------------------------------------------------------------
   // Counts
   // ------------------------------------------------------------
   localparam logic [3:0] ABORT_ONES = 4'd8;
   localparam logic [4:0] CLEAR_BITS = 5'd30;
   localparam logic [3:0] CLK_LOSS_TICKS = 4'd15;
   localparam logic [3:0] BYTE_BITS = 4'd8;
   localparam logic [4:0] FRAME_BITS = 5'd16;
   localparam logic [2:0] REP_MAX = 3'd7;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_WIDTH = 8;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      TX_IDLE = 3'b001,
      TX_DATA = 3'b010,
      TX_CODE = 3'b100
   } bcc_tx_e;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } bcc_bus_s;

   // Repeats needed for a valid code from the filter field
   function automatic logic [2:0] filt_need(input logic [1:0] sel);
      case (sel)
         2'b00: filt_need = 3'd1;
         2'b01: filt_need = 3'd3;
         2'b10: filt_need = 3'd5;
         default: filt_need = 3'd7;
      endcase
   endfunction

   // Code frame, sent bit 0 first: eight ones, 0, code LSB first, 0
   function automatic logic [15:0] code_frame(input logic [5:0] code);
      code_frame = {1'b0, code, 1'b0, 8'hFF};
   endfunction

endpackage

// [bcc_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
module bcc_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // Level
   output logic full
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // Handshake and level flags
   assign full = (cnt_r == (AW + 1)'(D));
   assign in_ready = ~full;
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update
   always_comb begin
      wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // State registers and storage
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         cnt_r <= cnt_nxt;
      end
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

endmodule

// [bcc_far_end.sv]
// Far-end link model: bit slot requests and receive bit source
module bcc_far_end (
   // Clock
   input wire logic sys_clk,
   // Device transmit side
   input wire logic fdl_tx_bit,
   output logic fdl_tx_req,
   output logic [15:0] tx_hist,
   // Device receive side
   input wire logic fdl_rx_ready,
   output logic fdl_rx_valid,
   output logic fdl_rx_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph = 2'h0;
   initial begin
      fdl_tx_req = 1'b0;
      tx_hist = 16'hFFFF;
      fdl_rx_valid = 1'b0;
      fdl_rx_bit = 1'b0;
   end
   // ----
   // Slot every fourth cycle, bit captured two cycles on
   // ----
   always @(posedge sys_clk) begin
      ph <= ph + 2'h1;
      fdl_tx_req <= (ph == 2'h3);
      if (ph == 2'h2) tx_hist <= {fdl_tx_bit, tx_hist[15:1]};
   end
   // One bit held until taken or 40 cycles pass; line inverted once released
   task automatic put_bit(input logic b);
      int n;
      logic ok;
      n = 0;
      ok = 1'b0;
      @(posedge sys_clk);
      fdl_rx_valid <= 1'b1;
      fdl_rx_bit <= b;
      while (!ok && n < 40) begin
         @(negedge sys_clk);
         ok = fdl_rx_ready;
         @(posedge sys_clk);
         n++;
      end
      fdl_rx_valid <= 1'b0;
      fdl_rx_bit <= ~b;
   endtask
   // Several bits, bit 0 first
   task automatic put_bits(input logic [63:0] v, input int n);
      for (int i = 0; i < n; i++) put_bit(v[i]);
   endtask
endmodule

// [bcc_ctrl_monitor.sv]
// Port checks for the code controller
module bcc_ctrl_monitor (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register port
   input wire bcc_pkg::bcc_bus_s reg_bus,
   input wire logic [7:0] reg_rdata,
   // Line and link
   input wire logic t1_mode,
   input wire logic alarm_ci_detect,
   input wire logic fdl_tx_req,
   input wire logic fdl_tx_bit,
   input wire logic fdl_rx_ready,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [23:0] wv_r;
   logic [23:0] wv_nxt;
   // ----
   // Shadow of written control, mask and match a
   // ----
   always_comb begin
      wv_nxt = wv_r;
      if (reg_bus.wr && reg_bus.addr == bcc_pkg::OFF_CTRL) wv_nxt[7:0] = reg_bus.wdata & 8'h1F;
      if (reg_bus.wr && reg_bus.addr == bcc_pkg::OFF_MASK) wv_nxt[15:8] = reg_bus.wdata;
      if (reg_bus.wr && reg_bus.addr == bcc_pkg::OFF_MATCH_A) wv_nxt[23:16] = reg_bus.wdata;
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) wv_r <= 24'h0;
      else wv_r <= wv_nxt;
   end
   // Alarm seen, quiet cycle, then a status read
   sequence s_alarm_read;
      t1_mode && alarm_ci_detect ##1 !reg_bus.rd
         ##1 reg_bus.rd && reg_bus.addr == bcc_pkg::OFF_STATUS;
   endsequence
   // ----
   // Assertions
   // ----
   a_reset_out: assert property (
      disable iff (1'b0) !rst_n |=> !irq && fdl_tx_bit && fdl_rx_ready && reg_rdata == 8'h00)
      else $error("outputs not at reset values");
   a_tx_hold: assert property (
      !fdl_tx_req |=> $stable(fdl_tx_bit)) else $error("link bit moved without slot");
   a_rdata_hold: assert property (
      !reg_bus.rd |=> $stable(reg_rdata)) else $error("read data moved without read");
   a_ctrl_rdbk: assert property (
      reg_bus.rd && reg_bus.addr == bcc_pkg::OFF_CTRL |=> reg_rdata == wv_r[7:0])
      else $error("control readback wrong");
   a_mask_rdbk: assert property (
      reg_bus.rd && reg_bus.addr == bcc_pkg::OFF_MASK |=> reg_rdata == wv_r[15:8])
      else $error("mask readback wrong");
   a_match_rdbk: assert property (
      reg_bus.rd && reg_bus.addr == bcc_pkg::OFF_MATCH_A |=> reg_rdata == wv_r[23:16])
      else $error("match readback wrong");
   a_alarm_status: assert property (
      s_alarm_read |=> reg_rdata[7]) else $error("alarm event not in status");
   a_unmapped_zero: assert property (
      reg_bus.rd && (reg_bus.addr == 8'h20 || reg_bus.addr == bcc_pkg::OFF_TX_LINK)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule
bind bcc_ctrl bcc_ctrl_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .reg_bus(reg_bus),
   .reg_rdata(reg_rdata), .t1_mode(t1_mode), .alarm_ci_detect(alarm_ci_detect),
   .fdl_tx_req(fdl_tx_req), .fdl_tx_bit(fdl_tx_bit), .fdl_rx_ready(fdl_rx_ready), .irq(irq));

// [bcc_ctrl_tb_top.sv]
// Self-checking bench for the code controller
module bcc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [1:0] sel;
      logic [5:0] code;
      logic [3:0] need;
   } bcc_row_s;
   bcc_row_s rows [4] = '{'{2'h0, 6'h05, 4'h1}, '{2'h1, 6'h12, 4'h3},
      '{2'h2, 6'h2A, 4'h5}, '{2'h3, 6'h0C, 4'h7}};
   logic [7:0] adr [8] = '{8'h18, 8'h19, 8'h1F, 8'h50, 8'h51, 8'h52, 8'h53, 8'h20};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   bcc_pkg::bcc_bus_s bus = '0;
   logic t1_mode = 1'b1;
   logic alarm = 1'b0;
   logic tx_clock_pin = 1'b0;
   logic tick = 1'b0;
   logic fdl_tx_req, fdl_tx_bit, fdl_rx_valid, fdl_rx_bit, fdl_rx_ready, irq;
   logic [7:0] reg_rdata, v;
   logic [15:0] tx_hist;
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   // Clock
   always #25 sys_clk = ~sys_clk;
   bcc_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_bus(bus), .reg_rdata(reg_rdata),
      .t1_mode(t1_mode), .alarm_ci_detect(alarm), .tx_clock_pin(tx_clock_pin),
      .mclk_scaled_tick(tick), .fdl_tx_req(fdl_tx_req), .fdl_tx_bit(fdl_tx_bit),
      .fdl_rx_valid(fdl_rx_valid), .fdl_rx_bit(fdl_rx_bit), .fdl_rx_ready(fdl_rx_ready),
      .irq(irq));
   bcc_far_end far (.sys_clk(sys_clk), .fdl_tx_bit(fdl_tx_bit), .fdl_tx_req(fdl_tx_req),
      .tx_hist(tx_hist), .fdl_rx_ready(fdl_rx_ready), .fdl_rx_valid(fdl_rx_valid),
      .fdl_rx_bit(fdl_rx_bit));
   // ----
   // Helpers
   // ----
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic frame(input logic [5:0] c);
      far.put_bits({48'h0, 1'b0, c, 1'b0, 8'hFF}, 16);
   endtask
   task automatic pulse_alarm();
      @(posedge sys_clk);
      alarm <= 1'b1;
      @(posedge sys_clk);
      alarm <= 1'b0;
      #1;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         tick <= 1'b1;
         @(posedge sys_clk);
         tick <= 1'b0;
      end
   endtask
   task automatic see(input string nm, input logic [15:0] p, input logic [15:0] m);
      int n;
      n = 0;
      while ((tx_hist & m) !== p && n < 150) begin
         @(posedge sys_clk);
         n++;
      end
      chk(nm, tx_hist & m, p);
   endtask
   task automatic fin(input string nm);
      $display("test %s done, mismatches so far %0d", nm, err_total);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Cycle ceiling
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   // ----
   // Main sequence
   // ----
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      wr(bcc_pkg::OFF_CTRL, 8'hE0);
      foreach (adr[i]) begin
         rd(adr[i]);
         chk("reset value", v, 8'h00);
      end
      fin("reset");
      // Receive buffer filled until refused, then drained
      for (int i = 1; i <= 8; i++) far.put_bits(64'(i * 8'h11), 8);
      #1 chk("rx ready", fdl_rx_ready, 1'b0);
      @(posedge sys_clk);
      rd(bcc_pkg::OFF_STATUS);
      chk("full event", v[3], 1'b1);
      for (int i = 1; i <= 9; i++) begin
         rd(bcc_pkg::OFF_RX_LINK);
         chk("rx byte", v, (i < 9) ? 8'(i * 8'h11) : 8'h00);
      end
      fin("buffer");
      // Filter table rows
      foreach (rows[i]) begin
         wr(bcc_pkg::OFF_MATCH_A, {2'h0, rows[i].code});
         wr(bcc_pkg::OFF_CTRL, 8'h00);
         wr(bcc_pkg::OFF_CTRL, {3'h0, 2'h2, rows[i].sel, 1'b0});
         rd(bcc_pkg::OFF_RX_LINK);
         chk("preset", v, 8'h3F);
         repeat (rows[i].need - 1) frame(rows[i].code);
         rd(bcc_pkg::OFF_RX_LINK);
         chk("early code", v, 8'h3F);
         rd(bcc_pkg::OFF_STATUS);
         frame(rows[i].code);
         rd(bcc_pkg::OFF_RX_LINK);
         chk("code", v, {2'h0, rows[i].code});
         rd(bcc_pkg::OFF_STATUS);
         chk("code events", v & 8'h03, 8'h03);
      end
      fin("filter");
      // Detector reset on a rising reset bit with receive enable held, not on a held reset bit
      wr(bcc_pkg::OFF_CTRL, 8'h18);
      rd(bcc_pkg::OFF_RX_LINK);
      chk("reset bit", v, 8'h3F);
      frame(6'h21);
      wr(bcc_pkg::OFF_CTRL, 8'h18);
      rd(bcc_pkg::OFF_RX_LINK);
      chk("reset held", v, 8'h21);
      wr(bcc_pkg::OFF_CTRL, 8'h10);
      wr(bcc_pkg::OFF_CTRL, 8'h18);
      rd(bcc_pkg::OFF_RX_LINK);
      chk("reset again", v, 8'h3F);
      fin("detector reset");
      // Abort after eight ones, clear after thirty quiet bits
      rd(bcc_pkg::OFF_STATUS);
      far.put_bits(64'hFF, 8);
      far.put_bits(64'h0, 21);
      rd(bcc_pkg::OFF_STATUS);
      chk("abort", v & 8'h30, 8'h10);
      far.put_bits(64'h0, 9);
      rd(bcc_pkg::OFF_STATUS);
      chk("clear", v & 8'h30, 8'h20);
      fin("abort");
      // Transmit clock loss after fifteen quiet ticks
      tx_clock_pin <= 1'b1;
      rd(bcc_pkg::OFF_STATUS);
      ticks(14);
      rd(bcc_pkg::OFF_STATUS);
      chk("loss early", v[6], 1'b0);
      ticks(1);
      rd(bcc_pkg::OFF_STATUS);
      chk("loss", v[6], 1'b1);
      fin("clock loss");
      // Alarm event, mask and interrupt
      wr(bcc_pkg::OFF_MASK, 8'h80);
      rd(bcc_pkg::OFF_STATUS);
      t1_mode <= 1'b0;
      pulse_alarm();
      rd(bcc_pkg::OFF_STATUS);
      chk("alarm off mode", v[7], 1'b0);
      t1_mode <= 1'b1;
      pulse_alarm();
      chk("irq on", irq, 1'b1);
      wr(bcc_pkg::OFF_MASK, 8'h00);
      chk("irq masked", irq, 1'b0);
      wr(bcc_pkg::OFF_MASK, 8'h80);
      chk("irq unmasked", irq, 1'b1);
      rd(bcc_pkg::OFF_STATUS);
      chk("alarm", v[7], 1'b1);
      rd(bcc_pkg::OFF_STATUS);
      chk("alarm cleared", v[7], 1'b0);
      chk("irq off", irq, 1'b0);
      pulse_alarm();
      rd(bcc_pkg::OFF_STATUS);
      chk("alarm again", v[7], 1'b1);
      fin("alarm");
      // Data byte, then repeated code frames
      wr(bcc_pkg::OFF_CTRL, 8'h00);
      rd(bcc_pkg::OFF_STATUS);
      wr(bcc_pkg::OFF_TX_LINK, 8'h35);
      see("tx byte", 16'h3500, 16'hFF00);
      rd(bcc_pkg::OFF_STATUS);
      chk("tx empty", v[2], 1'b1);
      wr(bcc_pkg::OFF_TX_LINK, 8'hC5);
      wr(bcc_pkg::OFF_CTRL, 8'h01);
      see("code frame", {1'b0, 6'h05, 1'b0, 8'hFF}, 16'hFFFF);
      repeat (8) @(posedge sys_clk);
      see("code again", {1'b0, 6'h05, 1'b0, 8'hFF}, 16'hFFFF);
      wr(bcc_pkg::OFF_CTRL, 8'h00);
      repeat (200) @(posedge sys_clk);
      chk("code stop", tx_hist, 16'hFFFF);
      fin("transmit");
      summarize();
   end
endmodule
